// ### hw/gpu_defines.vh
// constants for the port block: register offsets, field positions, reset values, timing
`ifndef GPU_DEFINES_VH
`define GPU_DEFINES_VH

// =========================================================
// register offsets (word index on the register port)
`define GPU_OFS_OUT0 4'h0
`define GPU_OFS_OUT1 4'h1
`define GPU_OFS_OUT2 4'h2
`define GPU_OFS_DIR0 4'h3
`define GPU_OFS_DIR1 4'h4
`define GPU_OFS_DIR2 4'h5
`define GPU_OFS_PULL0 4'h6
`define GPU_OFS_PULL1 4'h7
`define GPU_OFS_PULL2 4'h8
`define GPU_OFS_MODEN 4'h9
`define GPU_OFS_ALT 4'ha
`define GPU_OFS_IN0 4'hb
`define GPU_OFS_IN1 4'hc
`define GPU_OFS_IN2 4'hd

// =========================================================
// reset values
`define GPU_RST_OUT 8'hff
`define GPU_RST_DIR 8'h00
`define GPU_RST_PULL 8'h00
`define GPU_RST_MODEN 8'h00
`define GPU_RST_ALT 8'h00

// =========================================================
// alternate function control bits
`define GPU_ALT_SERIAL 0
`define GPU_ALT_PULSE1 1
`define GPU_ALT_PULSE2 2
`define GPU_ALT_TXD 3

// =========================================================
// pin positions in the flat 20-pin vector (port0 0..7, port1 8..15, port2 16..19)
`define GPU_PIN_SCL 6
`define GPU_PIN_SDA 4
`define GPU_PIN_PULSE1 2
`define GPU_PIN_PULSE2 3
`define GPU_PIN_TXD 9
`define GPU_PIN_RXD 8
`define GPU_PIN_P0_5 5
`define GPU_PIN_P0_7 7
`define GPU_PIN_P1_4 12
`define GPU_PIN_P1_5 13
`define GPU_PIN_P1_6 14

// =========================================================
// modulation enable bit positions
`define GPU_MOD_P0_2 0
`define GPU_MOD_P0_3 1
`define GPU_MOD_P0_5 2
`define GPU_MOD_P0_7 3
`define GPU_MOD_P1_1 4
`define GPU_MOD_P1_4 5
`define GPU_MOD_P1_5 6
`define GPU_MOD_P1_6 7

// =========================================================
// timing
`define GPU_CLK_HZ 10000000
`define GPU_CARRIER_HZ 38000

`endif

// ### hw/gpu_carrier.v
// carrier square wave generator from a half-period enable divider
`timescale 1ns/1ps

module gpu_carrier #(
    parameter HALF_CNT = 131
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_sync_n,
    // carrier out
    output reg carrier_reg
);

    reg [7:0] div_reg;
    wire half_tick;

    // =========================================================
    // divider
    // one-cycle enable at each half period
    assign half_tick = (div_reg == HALF_CNT[7:0] - 8'h01);

    always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_reg <= 8'h00;
        end else if (half_tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // =========================================================
    // square wave
    always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            carrier_reg <= 1'b0;
        end else if (half_tick) begin
            carrier_reg <= ~carrier_reg;
        end
    end

endmodule

// ### hw/gpu_port.v
// twenty-pin port logic with pull-up control, carrier modulation and pulse outputs
//
// Behaviour
// - twenty pins, six of them (pins 2, 3, 4, 6, 8, 9) also serving an alternate peripheral function
// - each pin's weak pull-up can be disabled on its own by software
// - serial clock and data pins are open-drain while serial enabled and core running
// - in sleep, serial pin pull-ups stay on by default unless software disabled them
// - pull-up map 0 bit 6 disables serial clock pull-up, bit 4 serial data
// - modulated pin output is its port or alternate-function level ORed with the 38 kHz carrier
// - modulation only on port1 bits 4,5,6, transmit pin, port0 bits 7,5,3,2
// - each modulation-capable pin has its own enable bit
// - energy pulse outputs idle high and pulse low
`timescale 1ns/1ps
`include "gpu_defines.vh"

module gpu_port #(
    parameter NPINS = 20,
    parameter CLK_HZ = `GPU_CLK_HZ,
    parameter CARRIER_HZ = `GPU_CARRIER_HZ
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // core state
    input wire core_sleep,
    // alternate function sources
    input wire serial_scl_low,
    input wire serial_sda_low,
    input wire energy_pulse_1,
    input wire energy_pulse_2,
    input wire uart_txd,
    // alternate function sinks
    output wire serial_scl_in,
    output wire serial_data_pin_in,
    output wire uart_rxd,
    output wire energy_pulse_out_1,
    output wire energy_pulse_out_2,
    // pads
    input wire [NPINS-1:0] pad_in,
    output reg [NPINS-1:0] pad_out,
    output reg [NPINS-1:0] pad_oe,
    output reg [NPINS-1:0] pad_pullup_en
);

    localparam HALF_CNT = CLK_HZ / (2 * CARRIER_HZ);
    // reset values held at full width so the narrow registers take a slice on purpose
    localparam [7:0] RST_OUT = `GPU_RST_OUT;
    localparam [7:0] RST_DIR = `GPU_RST_DIR;
    localparam [7:0] RST_PULL = `GPU_RST_PULL;
    localparam [7:0] RST_ALT = `GPU_RST_ALT;

    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_sync_n;
    reg [NPINS-1:0] in_meta_reg;
    reg [NPINS-1:0] in_sync_reg;
    reg [7:0] out0_reg;
    reg [7:0] out1_reg;
    reg [3:0] out2_reg;
    reg [7:0] dir0_reg;
    reg [7:0] dir1_reg;
    reg [3:0] dir2_reg;
    reg [7:0] pullup_map_reg_0;
    reg [7:0] pullup_map_reg_1;
    reg [3:0] pullup_map_reg_2;
    reg [7:0] mod_en_reg;
    reg [3:0] alt_reg;
    reg [7:0] rdata_next;
    reg [NPINS-1:0] out_next;
    reg [NPINS-1:0] oe_next;
    reg [NPINS-1:0] mod_vec;
    wire carrier;
    wire [NPINS-1:0] data_vec;
    wire [NPINS-1:0] dir_vec;
    wire [NPINS-1:0] pull_dis_vec;
    wire serial_run;

    // upper nibble of the narrow registers always reads as zero
    function [7:0] zext4;
        input [3:0] v;
        begin
            zext4 = {4'h0, v};
        end
    endfunction

    // =========================================================
    // reset release
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_sync_n = rst_sync_reg;

    // =========================================================
    // pad input synchroniser
    always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_meta_reg <= {NPINS{1'b1}};
            in_sync_reg <= {NPINS{1'b1}};
        end else begin
            in_meta_reg <= pad_in;
            in_sync_reg <= in_meta_reg;
        end
    end

    assign serial_scl_in = in_sync_reg[`GPU_PIN_SCL];
    assign serial_data_pin_in = in_sync_reg[`GPU_PIN_SDA];
    assign uart_rxd = in_sync_reg[`GPU_PIN_RXD];

    // =========================================================
    // register writes
    // settings only change on writes, so sleep keeps them
    always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out0_reg <= `GPU_RST_OUT;
            out1_reg <= `GPU_RST_OUT;
            out2_reg <= RST_OUT[3:0];
            dir0_reg <= `GPU_RST_DIR;
            dir1_reg <= `GPU_RST_DIR;
            dir2_reg <= RST_DIR[3:0];
            pullup_map_reg_0 <= `GPU_RST_PULL;
            pullup_map_reg_1 <= `GPU_RST_PULL;
            pullup_map_reg_2 <= RST_PULL[3:0];
            mod_en_reg <= `GPU_RST_MODEN;
            alt_reg <= RST_ALT[3:0];
        end else if (reg_wr) begin
            case (reg_addr)
                `GPU_OFS_OUT0: out0_reg <= reg_wdata;
                `GPU_OFS_OUT1: out1_reg <= reg_wdata;
                `GPU_OFS_OUT2: out2_reg <= reg_wdata[3:0];
                `GPU_OFS_DIR0: dir0_reg <= reg_wdata;
                `GPU_OFS_DIR1: dir1_reg <= reg_wdata;
                `GPU_OFS_DIR2: dir2_reg <= reg_wdata[3:0];
                `GPU_OFS_PULL0: pullup_map_reg_0 <= reg_wdata;
                `GPU_OFS_PULL1: pullup_map_reg_1 <= reg_wdata;
                `GPU_OFS_PULL2: pullup_map_reg_2 <= reg_wdata[3:0];
                `GPU_OFS_MODEN: mod_en_reg <= reg_wdata;
                `GPU_OFS_ALT: alt_reg <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // =========================================================
    // register reads
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `GPU_OFS_OUT0: rdata_next = out0_reg;
            `GPU_OFS_OUT1: rdata_next = out1_reg;
            `GPU_OFS_OUT2: rdata_next = zext4(out2_reg);
            `GPU_OFS_DIR0: rdata_next = dir0_reg;
            `GPU_OFS_DIR1: rdata_next = dir1_reg;
            `GPU_OFS_DIR2: rdata_next = zext4(dir2_reg);
            `GPU_OFS_PULL0: rdata_next = pullup_map_reg_0;
            `GPU_OFS_PULL1: rdata_next = pullup_map_reg_1;
            `GPU_OFS_PULL2: rdata_next = zext4(pullup_map_reg_2);
            `GPU_OFS_MODEN: rdata_next = mod_en_reg;
            `GPU_OFS_ALT: rdata_next = zext4(alt_reg);
            `GPU_OFS_IN0: rdata_next = in_sync_reg[7:0];
            `GPU_OFS_IN1: rdata_next = in_sync_reg[15:8];
            `GPU_OFS_IN2: rdata_next = zext4(in_sync_reg[19:16]);
            default: rdata_next = 8'h00;
        endcase
    end

    // data valid only in the cycle after the read strobe
    always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // =========================================================
    // carrier source
    gpu_carrier #(
        .HALF_CNT(HALF_CNT)
    ) u_carrier (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .carrier_reg(carrier)
    );

    // =========================================================
    // pin output logic
    assign data_vec = {out2_reg, out1_reg, out0_reg};
    assign dir_vec = {dir2_reg, dir1_reg, dir0_reg};
    assign pull_dis_vec = {pullup_map_reg_2, pullup_map_reg_1, pullup_map_reg_0};
    // the serial peripheral stops with the core, so it drives nothing in sleep
    assign serial_run = alt_reg[`GPU_ALT_SERIAL] & ~core_sleep;

    // only the listed pins can take the carrier
    always @* begin
        mod_vec = {NPINS{1'b0}};
        mod_vec[`GPU_PIN_PULSE1] = mod_en_reg[`GPU_MOD_P0_2];
        mod_vec[`GPU_PIN_PULSE2] = mod_en_reg[`GPU_MOD_P0_3];
        mod_vec[`GPU_PIN_P0_5] = mod_en_reg[`GPU_MOD_P0_5];
        mod_vec[`GPU_PIN_P0_7] = mod_en_reg[`GPU_MOD_P0_7];
        mod_vec[`GPU_PIN_TXD] = mod_en_reg[`GPU_MOD_P1_1];
        mod_vec[`GPU_PIN_P1_4] = mod_en_reg[`GPU_MOD_P1_4];
        mod_vec[`GPU_PIN_P1_5] = mod_en_reg[`GPU_MOD_P1_5];
        mod_vec[`GPU_PIN_P1_6] = mod_en_reg[`GPU_MOD_P1_6];
    end

    always @* begin
        out_next = data_vec;
        oe_next = dir_vec;
        if (alt_reg[`GPU_ALT_SERIAL]) begin
            out_next[`GPU_PIN_SCL] = 1'b0;
            out_next[`GPU_PIN_SDA] = 1'b0;
            oe_next[`GPU_PIN_SCL] = serial_run & serial_scl_low;
            oe_next[`GPU_PIN_SDA] = serial_run & serial_sda_low;
        end
        if (alt_reg[`GPU_ALT_PULSE1]) begin
            out_next[`GPU_PIN_PULSE1] = ~energy_pulse_1;
            oe_next[`GPU_PIN_PULSE1] = 1'b1;
        end
        if (alt_reg[`GPU_ALT_PULSE2]) begin
            out_next[`GPU_PIN_PULSE2] = ~energy_pulse_2;
            oe_next[`GPU_PIN_PULSE2] = 1'b1;
        end
        if (alt_reg[`GPU_ALT_TXD]) begin
            out_next[`GPU_PIN_TXD] = uart_txd;
            oe_next[`GPU_PIN_TXD] = 1'b1;
        end
        out_next = out_next | (mod_vec & {NPINS{carrier}});
    end

    // registered pads; one cycle of latency from any source
    always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pad_out <= {NPINS{1'b1}};
            pad_oe <= {NPINS{1'b0}};
            pad_pullup_en <= {NPINS{1'b1}};
        end else begin
            pad_out <= out_next;
            pad_oe <= oe_next;
            // map 0 bits 6 and 4 switch off the serial pull-ups
            pad_pullup_en <= ~pull_dis_vec;
        end
    end

    // the low-going pulses as seen at the pins
    assign energy_pulse_out_1 = pad_out[`GPU_PIN_PULSE1];
    assign energy_pulse_out_2 = pad_out[`GPU_PIN_PULSE2];

endmodule

// ### verif/gpu_port_properties.sv
// assertion checker for the port block
`timescale 1ns/1ps
module gpu_port_chk #(
    parameter NPINS = 20
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    // core and sources
    input wire core_sleep,
    input wire serial_scl_low,
    input wire energy_pulse_1,
    // pads
    input wire [NPINS-1:0] pad_out,
    input wire [NPINS-1:0] pad_oe,
    input wire [NPINS-1:0] pad_pullup_en
);
// ==========
// shadows change at the design's own edge, so they hold what the pads are built from
reg [7:0] out0_q, out1_q, pull0_q, mod_q, alt_q;
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        {out0_q, out1_q} <= 16'hffff;
        {pull0_q, mod_q, alt_q} <= 24'h0;
    end else if (reg_wr) begin
        case (reg_addr)
            4'h0: out0_q <= reg_wdata;
            4'h1: out1_q <= reg_wdata;
            4'h6: pull0_q <= reg_wdata;
            4'h9: mod_q <= reg_wdata;
            4'ha: alt_q <= reg_wdata;
            default: ;
        endcase
    end
end
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
// ==========
// assertions
property p_pull0; reg_wr && reg_addr == 4'h6 |-> ##2 pad_pullup_en[7:0] == ~$past(reg_wdata, 2);
endproperty
a_pull0: assert property (p_pull0) else $error("map 0 not on pads");
property p_pull2; reg_wr && reg_addr == 4'h8 |-> ##2 pad_pullup_en[19:16] == ~$past(reg_wdata[3:0], 2);
endproperty
a_pull2: assert property (p_pull2) else $error("map 2 not on pads");
property p_od; alt_q[0] && !core_sleep && serial_scl_low |=> pad_oe[6] && !pad_out[6]; endproperty
a_od: assert property (p_od) else $error("clock pin not pulled low");
property p_slp; alt_q[0] && core_sleep |=> !pad_oe[6] && !pad_oe[4]; endproperty
a_slp: assert property (p_slp) else $error("serial pin driven in sleep");
property p_slpu; core_sleep && !pull0_q[6] && !pull0_q[4] |=> pad_pullup_en[6] && pad_pullup_en[4];
endproperty
a_slpu: assert property (p_slpu) else $error("serial pull-up off in sleep");
property p_one; mod_q[3] && out0_q[7] |=> pad_out[7]; endproperty
a_one: assert property (p_one) else $error("modulated one not high");
property p_nomod; 1'b1 |=> (pad_out[15:0] & 16'h8d03) == ({$past(out1_q), $past(out0_q)} & 16'h8d03);
endproperty
a_nomod: assert property (p_nomod) else $error("plain pin not at port level");
property p_pulse; alt_q[1] && !mod_q[0] |=> pad_oe[2] && pad_out[2] == !$past(energy_pulse_1);
endproperty
a_pulse: assert property (p_pulse) else $error("pulse pin polarity");
endmodule

bind gpu_port gpu_port_chk #(.NPINS(NPINS)) i_gpu_port_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .core_sleep(core_sleep),
    .serial_scl_low(serial_scl_low), .energy_pulse_1(energy_pulse_1), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en));

// ### verif/gpu_board.sv
// board model: external serial pull-ups and floating pads
`timescale 1ns/1ps
module gpu_board #(
    parameter EXT_PU = 20'h00050
) (
    // clock
    input wire sys_clk,
    // pads
    input wire [19:0] pad_out,
    input wire [19:0] pad_oe,
    input wire [19:0] pad_pullup_en,
    output wire [19:0] pad_in
);
// ==========
// a pad with no driver and no pull-up floats: flip it each cycle so no stale level passes
reg flt = 1'b0;
always @(posedge sys_clk) begin
    flt <= ~flt;
end
assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup_en | EXT_PU | {20{flt}}));
endmodule

// ### verif/test_gpu_port.sv
// self-checking bench for the port block
`timescale 1ns/1ps
module test_gpu_port;
reg sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, core_sleep = 0;
reg scl_lo = 0, sda_lo = 0, ep1 = 0, ep2 = 0, txd = 0;
reg [3:0] reg_addr = 0;
reg [7:0] reg_wdata = 0;
wire [7:0] reg_rdata;
wire scl_in, sda_in, rxd, ep_out1, ep_out2;
wire [19:0] pad_in, pad_out, pad_oe, pad_pu;
integer mismatches = 0, n_checks = 0, cyc = 0, i, k;
reg [19:0] tog, prv;
reg [15:0] rows [0:16] = '{16'h00a5, 16'h013c, 16'h02fa, 16'h03ff, 16'h04ff, 16'h050f, 16'h0ee5,
    16'h10a5, 16'h113c, 16'h120a, 16'h13ff, 16'h150f, 16'h1e00, 16'h1a00, 16'h1ba5, 16'h1c3c,
    16'h1d0a};
reg [4:0] pins [0:7] = '{5'd2, 5'd3, 5'd5, 5'd7, 5'd9, 5'd12, 5'd13, 5'd14};
always #50 sys_clk = ~sys_clk;
// carrier half period is 10 cycles at this clock setting
gpu_port #(.CLK_HZ(760000)) i_gpu_port (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_sleep(core_sleep), .serial_scl_low(scl_lo), .serial_sda_low(sda_lo),
    .energy_pulse_1(ep1), .energy_pulse_2(ep2), .uart_txd(txd), .serial_scl_in(scl_in),
    .serial_data_pin_in(sda_in), .uart_rxd(rxd), .energy_pulse_out_1(ep_out1),
    .energy_pulse_out_2(ep_out2), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pu));
gpu_board i_gpu_board (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pu), .pad_in(pad_in));
// ==========
// tasks
task chk(input [19:0] got, input [19:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
task op(input w, input r, input [3:0] a, input [7:0] d);
    begin
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    end
endtask
// outputs are read just after an edge, before that edge's updates land
task rdchk(input [3:0] a, input [7:0] e);
    begin
        op(0, 1, a, 8'h00);
        op(0, 0, 4'h0, 8'h00);
        chk(20'(reg_rdata), 20'(e));
    end
endtask
// strobes are one cycle long, so any wait first drops them
task wait_n(input integer n);
    begin
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    end
endtask
task watch;
    begin
        prv = pad_out;
        tog = 0;
        repeat (25) begin
            @(posedge sys_clk);
            tog = tog | (pad_out ^ prv);
            prv = pad_out;
        end
    end
endtask
task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
endtask
always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
        mismatches = mismatches + 1;
        print_verdict;
    end
end
// ==========
// main sequence
initial begin
    wait_n(8);
    rst_n <= 1;
    wait_n(3);
    for (i = 0; i < 17; i = i + 1) begin
        if (rows[i][12])
            rdchk(rows[i][11:8], rows[i][7:0]);
        else
            op(1, 0, rows[i][11:8], rows[i][7:0]);
    end
    chk(rxd, 20'h0);
    rst_n <= 0;
    wait_n(3);
    chk(pad_out ^ pad_oe ^ pad_pu, 20'h00000);
    rst_n <= 1;
    wait_n(3);
    op(1, 0, 4'h6, 8'h50);
    op(1, 0, 4'h8, 8'h09);
    wait_n(3);
    chk(pad_pu, 20'h6ffaf);
    core_sleep <= 1;
    wait_n(3);
    chk(pad_pu, 20'h6ffaf);
    op(1, 0, 4'h6, 8'h00);
    wait_n(3);
    chk(pad_pu, 20'h6ffff);
    core_sleep <= 0;
    op(1, 0, 4'ha, 8'h01);
    scl_lo <= 1;
    wait_n(5);
    chk({pad_oe[6], pad_out[6], pad_oe[4], scl_in, sda_in}, 20'h11);
    core_sleep <= 1;
    wait_n(2);
    chk(pad_oe[6], 20'h0);
    core_sleep <= 0;
    scl_lo <= 0;
    op(1, 0, 4'ha, 8'h0e);
    wait_n(3);
    chk({ep_out1, ep_out2, pad_oe[3:2], pad_out[9]}, 20'h1e);
    ep1 <= 1;
    txd <= 1;
    wait_n(3);
    chk({ep_out1, ep_out2, pad_out[9]}, 20'h3);
    ep1 <= 0;
    ep2 <= 1;
    wait_n(3);
    chk({ep_out1, ep_out2}, 20'h2);
    op(1, 0, 4'ha, 8'h00);
    op(1, 0, 4'h0, 8'h00);
    op(1, 0, 4'h1, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
        op(1, 0, 4'h9, 8'h01 << i);
        wait_n(3);
        watch;
        chk(tog, 20'h1 << pins[i]);
    end
    for (i = 0; i < 2; i = i + 1) begin
        k = 0;
        prv = pad_out;
        while (pad_out[14] === prv[14] && k < 30) begin
            @(posedge sys_clk);
            k = k + 1;
        end
    end
    chk(20'(k), 20'h00a);
    op(1, 0, 4'h9, 8'h08);
    op(1, 0, 4'h0, 8'h80);
    wait_n(3);
    watch;
    chk({tog[7], pad_out[7]}, 20'h1);
    print_verdict;
end
endmodule
